// ---- rtl/utfc_pkg.sv ----
`default_nettype none
package utfc_pkg;
    // parallel character width
    localparam int unsigned UTFC_DATA_W = 8;
    // 16x clock ticks per bit: counter runs 0..15
    localparam logic [3:0] UTFC_TICK_LAST = 4'hf;
    // tick on which the final sixteenth of the last stop bit begins
    localparam logic [3:0] UTFC_TICK_EOC = 4'he;
    localparam logic [3:0] UTFC_TICK_ZERO = 4'h0;
    // shortest character is 5 bits: last data index 4
    localparam logic [2:0] UTFC_MIN_LAST_IDX = 3'h4;
    localparam logic [2:0] UTFC_IDX_ZERO = 3'h0;
    // format and data register reset values
    localparam logic [1:0] UTFC_LEN_RST = 2'h0;
    localparam logic UTFC_PAR_DIS_RST = 1'b0;
    localparam logic UTFC_EVEN_RST = 1'b0;
    localparam logic UTFC_TWO_STOP_RST = 1'b0;
    localparam logic [UTFC_DATA_W-1:0] UTFC_DATA_RST = 8'h00;
    // line levels
    localparam logic UTFC_MARK = 1'b1;
    localparam logic UTFC_SPACE = 1'b0;

    typedef enum logic [4:0] {
        UTFC_IDLE = 5'h01,
        UTFC_START = 5'h02,
        UTFC_DATA = 5'h04,
        UTFC_PARITY = 5'h08,
        UTFC_STOP = 5'h10
    } utfc_state_t;
endpackage : utfc_pkg
`default_nettype wire

// ---- rtl/utfc_parity.sv ----
`timescale 1ns/10ps
`default_nettype none
module utfc_parity (
    input wire logic [utfc_pkg::UTFC_DATA_W-1:0] i_data, // character
    input wire logic [1:0] i_char_length, // {hi, lo}
    input wire logic i_even_parity_select, // 1 even, 0 odd
    output logic o_parity_bit // bit to send
);
    import utfc_pkg::*;

    logic [UTFC_DATA_W-1:0] used;
    logic [2:0] last_idx;

    assign last_idx = 3'(UTFC_MIN_LAST_IDX + {1'b0, i_char_length});

    // only bits inside the selected length count
    genvar g;
    generate
        for (g = 0; g < UTFC_DATA_W; g = g + 1) begin : g_mask
            assign used[g] = i_data[g] & (3'(g) <= last_idx);
        end
    endgenerate

    // even: ones total even; odd: ones total odd
    assign o_parity_bit = i_even_parity_select ? (^used) : ~(^used);
endmodule : utfc_parity
`default_nettype wire

// ---- rtl/utfc_tx.sv ----
// Summary of operation
// - host pulses load strobe low; data captured on its rising edge
// - character-done rises for the final sixteenth of the last stop bit, stays high until next start
// - back-to-back sending: character-done high one sixteenth bit only
// - serial output high for mark, low for space, high when idle
// - eight data inputs, lsb first; short characters use low bits
// - format strobe high loads parity, stop and length settings
// - parity disable drops parity bit; stops follow last data bit
// - parity disabled: receive parity error output held low
// - one stop bit when select low, two when high
// - length inputs hi,lo: 00=5, 01=6, 10=7, 11=8 bits
// - parity sense low gives odd parity, high gives even
// - holding-empty high when holding register can take a character
// - waiting character moves to shifter when shifter empties
// - master reset clears registers, sets output and both flags high
`timescale 1ns/10ps
`default_nettype none
module utfc_tx (
    input wire logic i_clk, // 40 MHz system clock
    input wire logic i_sys_rst, // sync reset, active high
    input wire logic i_master_reset_in, // external reset, active high
    input wire logic i_load_strobe_n, // data load strobe, active low
    input wire logic [utfc_pkg::UTFC_DATA_W-1:0] i_tx_parallel_in, // data
    input wire logic i_format_latch, // format strobe, active high
    input wire logic i_parity_disable, // 1 = no parity bit
    input wire logic i_two_stop_select, // 1 = two stop bits
    input wire logic i_char_length_hi, // length select high
    input wire logic i_char_length_lo, // length select low
    input wire logic i_even_parity_select, // 1 even, 0 odd
    input wire logic i_tx_bit_clock_16x, // 16x baud clock level
    input wire logic i_rx_parity_mismatch, // raw receiver parity check
    output logic o_serial_out, // serial line, idle high
    output logic o_char_done, // end of character flag
    output logic o_holding_empty, // holding register free
    output logic o_rx_parity_error, // gated receive parity error
    output logic [1:0] o_char_length, // held length {hi, lo}
    output logic o_parity_disable, // held parity disable
    output logic o_even_parity_select, // held parity sense
    output logic o_two_stop_select // held stop count
);
    import utfc_pkg::*;

    // ********************************
    // reset and input edges
    // ********************************
    logic rst;
    logic bclk_q;
    logic strobe_q;
    logic tick;
    logic load;

    assign rst = i_sys_rst | i_master_reset_in;

    always_ff @(posedge i_clk) begin
        if (rst) begin
            // track the free-running clock so release gives no false tick
            bclk_q <= i_tx_bit_clock_16x;
            strobe_q <= 1'b1;
        end else begin
            bclk_q <= i_tx_bit_clock_16x;
            strobe_q <= i_load_strobe_n;
        end
    end

    // each 16x rising edge is one sixteenth of a bit
    assign tick = i_tx_bit_clock_16x & ~bclk_q;
    // trailing (rising) edge of the low load pulse
    assign load = i_load_strobe_n & ~strobe_q;

    // ********************************
    // format holding register
    // ********************************
    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_char_length <= UTFC_LEN_RST;
            o_parity_disable <= UTFC_PAR_DIS_RST;
            o_even_parity_select <= UTFC_EVEN_RST;
            o_two_stop_select <= UTFC_TWO_STOP_RST;
        end else if (i_format_latch) begin
            o_char_length <= {i_char_length_hi, i_char_length_lo};
            o_parity_disable <= i_parity_disable;
            o_even_parity_select <= i_even_parity_select;
            o_two_stop_select <= i_two_stop_select;
        end
    end

    // receiver parity error forced low while parity is off
    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_rx_parity_error <= 1'b0;
        end else begin
            o_rx_parity_error <= i_rx_parity_mismatch & ~o_parity_disable;
        end
    end

    // ********************************
    // transmit holding register
    // ********************************
    utfc_state_t state;
    logic [UTFC_DATA_W-1:0] hold_data;
    logic [3:0] tick_cnt;
    logic [2:0] data_cnt;
    logic stop_cnt;
    logic bit_end;
    logic char_end;
    logic take;
    logic [2:0] last_idx;
    logic next_parity;

    assign bit_end = (tick_cnt == UTFC_TICK_LAST);
    assign char_end = (state == UTFC_STOP) && bit_end
                      && (stop_cnt == o_two_stop_select);
    // shifter is empty when idle or finishing its last stop bit
    assign take = tick && !o_holding_empty
                  && ((state == UTFC_IDLE) || char_end);
    assign last_idx = 3'(UTFC_MIN_LAST_IDX + {1'b0, o_char_length});

    always_ff @(posedge i_clk) begin
        if (rst) begin
            hold_data <= UTFC_DATA_RST;
        end else if (load) begin
            hold_data <= i_tx_parallel_in;
        end
    end

    // a load in the same cycle as a transfer keeps the register full
    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_holding_empty <= 1'b1;
        end else if (load) begin
            o_holding_empty <= 1'b0;
        end else if (take) begin
            o_holding_empty <= 1'b1;
        end
    end

    utfc_parity u_parity (
        .i_data(hold_data),
        .i_char_length(o_char_length),
        .i_even_parity_select(o_even_parity_select),
        .o_parity_bit(next_parity)
    );

    // ********************************
    // transmit shifter and sequencer
    // ********************************
    logic [UTFC_DATA_W-1:0] shreg;
    logic par_bit;

    always_ff @(posedge i_clk) begin
        if (rst) begin
            shreg <= UTFC_DATA_RST;
            par_bit <= 1'b0;
        end else if (take) begin
            shreg <= hold_data;
            par_bit <= next_parity;
        end else if (tick && bit_end && state == UTFC_DATA) begin
            shreg <= shreg >> 1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (rst) begin
            tick_cnt <= UTFC_TICK_ZERO;
        end else if (take || state == UTFC_IDLE) begin
            tick_cnt <= UTFC_TICK_ZERO;
        end else if (tick) begin
            tick_cnt <= tick_cnt + 4'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (rst) begin
            state <= UTFC_IDLE;
            data_cnt <= UTFC_IDX_ZERO;
            stop_cnt <= 1'b0;
        end else if (take) begin
            state <= UTFC_START;
        end else if (tick && bit_end) begin
            unique case (state)
                UTFC_IDLE: begin
                    state <= UTFC_IDLE;
                end
                UTFC_START: begin
                    state <= UTFC_DATA;
                    data_cnt <= UTFC_IDX_ZERO;
                end
                UTFC_DATA: begin
                    data_cnt <= data_cnt + 3'h1;
                    stop_cnt <= 1'b0;
                    if (data_cnt == last_idx) begin
                        state <= o_parity_disable ? UTFC_STOP
                                                  : UTFC_PARITY;
                    end
                end
                UTFC_PARITY: begin
                    state <= UTFC_STOP;
                    stop_cnt <= 1'b0;
                end
                UTFC_STOP: begin
                    if (char_end) begin
                        state <= UTFC_IDLE;
                    end else begin
                        stop_cnt <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ********************************
    // line and end-of-character flag
    // ********************************
    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_serial_out <= UTFC_MARK;
        end else begin
            unique case (state)
                UTFC_IDLE: o_serial_out <= UTFC_MARK;
                UTFC_START: o_serial_out <= UTFC_SPACE;
                UTFC_DATA: o_serial_out <= shreg[0];
                UTFC_PARITY: o_serial_out <= par_bit;
                UTFC_STOP: o_serial_out <= UTFC_MARK;
            endcase
        end
    end

    // raised for the final sixteenth of the last stop bit
    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_char_done <= 1'b1;
        end else if (tick && state == UTFC_STOP
                     && stop_cnt == o_two_stop_select
                     && tick_cnt == UTFC_TICK_EOC) begin
            o_char_done <= 1'b1;
        end else if (state == UTFC_START) begin
            o_char_done <= 1'b0;
        end
    end
endmodule : utfc_tx
`default_nettype wire

// ---- tb/utfc_far_end.sv ----
`timescale 1ns/10ps
`default_nettype none
module utfc_far_end (
    input wire logic i_clk, // system clock
    output logic o_tick_clk // 16x bit clock
);
    logic [1:0] div = 2'h0;
    // four system clocks a tick, 64 a bit
    always_ff @(posedge i_clk) begin
        div <= div + 2'h1;
    end
    assign o_tick_clk = div[1];
endmodule : utfc_far_end
`default_nettype wire

// ---- tb/utfc_tx_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module utfc_tx_checker (
    input wire logic i_clk, // clock
    input wire logic i_sys_rst, // reset
    input wire logic i_master_reset_in, // ext reset
    input wire logic i_load_strobe_n, // load
    input wire logic i_format_latch, // format strobe
    input wire logic i_parity_disable, // fmt
    input wire logic i_two_stop_select, // fmt
    input wire logic i_char_length_hi, // fmt
    input wire logic i_char_length_lo, // fmt
    input wire logic i_even_parity_select, // fmt
    input wire logic i_rx_parity_mismatch, // raw error
    input wire logic o_serial_out, // line
    input wire logic o_char_done, // done
    input wire logic o_holding_empty, // empty
    input wire logic o_rx_parity_error, // error
    input wire logic [1:0] o_char_length, // fmt
    input wire logic o_parity_disable, // fmt
    input wire logic o_even_parity_select, // fmt
    input wire logic o_two_stop_select // fmt
);
    logic rst_any;
    assign rst_any = i_sys_rst || i_master_reset_in;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (rst_any);
    sequence start_edge;
        $fell(o_serial_out) && $fell(o_char_done);
    endsequence
    a_reset_sys: assert property (disable iff (1'b0) i_sys_rst |=>
        o_serial_out && o_char_done && o_holding_empty && !o_rx_parity_error)
        else $error("bad state after reset");
    a_reset_master: assert property (disable iff (1'b0)
        i_master_reset_in |=> o_serial_out && o_char_done && o_holding_empty)
        else $error("bad state after master reset");
    a_format_load: assert property (i_format_latch |=>
        o_char_length == $past({i_char_length_hi, i_char_length_lo})
        && o_parity_disable == $past(i_parity_disable)
        && o_even_parity_select == $past(i_even_parity_select)
        && o_two_stop_select == $past(i_two_stop_select))
        else $error("format not loaded");
    a_parity_gate: assert property (1'b1 |=> o_rx_parity_error ==
        ($past(i_rx_parity_mismatch) && !$past(o_parity_disable)))
        else $error("parity error gating wrong");
    a_done_mark: assert property (o_char_done |-> o_serial_out)
        else $error("done while line low");
    a_done_clear: assert property ($fell(o_char_done) |-> start_edge)
        else $error("done cleared off start bit");
    a_start_hold: assert property (start_edge |-> !o_serial_out [*8])
        else $error("start bit too short");
    a_load_empty: assert property ($rose(i_load_strobe_n) |=>
        !o_holding_empty) else $error("load not taken");
    a_done_short: assert property ($rose(o_char_done) && !o_holding_empty
        |-> ##[1:8] $fell(o_char_done)) else $error("done pulse too long");
endmodule : utfc_tx_checker
bind utfc_tx utfc_tx_checker chk (.i_clk, .i_sys_rst, .i_master_reset_in,
    .i_load_strobe_n, .i_format_latch, .i_parity_disable, .i_two_stop_select,
    .i_char_length_hi, .i_char_length_lo, .i_even_parity_select,
    .i_rx_parity_mismatch, .o_serial_out, .o_char_done, .o_holding_empty,
    .o_rx_parity_error, .o_char_length, .o_parity_disable,
    .o_even_parity_select, .o_two_stop_select);
`default_nettype wire

// ---- tb/utfc_tx_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module utfc_tx_tb;
    import utfc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, mrst = 1'b0, ld_n = 1'b1, fl = 1'b0;
    logic pd = 1'b0, two = 1'b0, lh = 1'b0, ll = 1'b0, ev = 1'b0, pm = 1'b0;
    logic [7:0] din = 8'h00;
    logic tick, so, done, empty, perr, pd_q, ev_q, two_q;
    logic [1:0] len_q;
    logic [11:0] got;
    int fails = 0, total_checks = 0, n, c;
    always #12.5 clk = ~clk;
    utfc_far_end far (.i_clk(clk), .o_tick_clk(tick));
    utfc_tx DUT (.i_clk(clk), .i_sys_rst(rst), .i_master_reset_in(mrst),
        .i_load_strobe_n(ld_n), .i_tx_parallel_in(din), .i_format_latch(fl),
        .i_parity_disable(pd), .i_two_stop_select(two),
        .i_char_length_hi(lh), .i_char_length_lo(ll),
        .i_even_parity_select(ev), .i_tx_bit_clock_16x(tick),
        .i_rx_parity_mismatch(pm), .o_serial_out(so), .o_char_done(done),
        .o_holding_empty(empty), .o_rx_parity_error(perr),
        .o_char_length(len_q), .o_parity_disable(pd_q),
        .o_even_parity_select(ev_q), .o_two_stop_select(two_q));
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : check
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // f = {hi, lo, parity off, even, two stops}
    task automatic set_fmt(input logic [4:0] f);
        @(negedge clk);
        {lh, ll, pd, ev, two} = f;
        fl = 1'b1;
        @(negedge clk);
        fl = 1'b0;
        check({len_q, pd_q, ev_q, two_q}, f);
    endtask : set_fmt
    task automatic send(input logic [7:0] d);
        @(negedge clk);
        din = d;
        ld_n = 1'b0;
        @(negedge clk);
        ld_n = 1'b1;
    endtask : send
    task automatic expect_char(input logic [7:0] d, input logic [4:0] f);
        logic [11:0] e;
        logic [7:0] m;
        int k, nd;
        e = '1;
        e[0] = 1'b0;
        nd = 5 + f[4:3];
        m = d & (8'hff >> (8 - nd));
        for (k = 0; k < nd; k++) e[k+1] = m[k];
        k = nd + 1;
        if (!f[2]) begin
            e[k] = f[1] ? ^m : ~^m;
            k++;
        end
        n = k + 1 + f[0];
        k = 0;
        while (so !== 1'b0 && k < 5000) begin
            @(negedge clk);
            k++;
        end
        repeat (32) @(negedge clk);
        check(done, 1'b0);
        got = '1;
        for (k = 0; k < n; k++) begin
            if (k != 0) repeat (64) @(negedge clk);
            got[k] = so;
        end
        check(got, e);
        k = 0;
        while (done !== 1'b1 && k < 200) begin
            @(negedge clk);
            k++;
        end
        check({done, so}, 2'h3);
        // let the last stop bit end before the format may change
        repeat (8) @(negedge clk);
    endtask : expect_char
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        check({so, done, empty, perr, len_q, pd_q, ev_q, two_q}, 12'h1c0);
        $display("test reset finished");
        for (c = 0; c < 32; c++) begin
            set_fmt(c[4:0]);
            fork
                expect_char(8'h5a + 8'(c * 29), c[4:0]);
                send(8'h5a + 8'(c * 29));
            join
        end
        $display("test formats finished");
        set_fmt(5'h18);
        fork
            expect_char(8'ha7, 5'h18);
            begin
                send(8'ha7);
                repeat (8) @(negedge clk);
                send(8'h3c);
                repeat (3) @(negedge clk);
                check(empty, 1'b0);
            end
        join
        expect_char(8'h3c, 5'h18);
        repeat (80) @(negedge clk);
        check({done, empty, so}, 3'h7);
        $display("test back to back finished");
        pm = 1'b1;
        set_fmt(5'h04);
        repeat (2) @(negedge clk);
        check(perr, 1'b0);
        set_fmt(5'h00);
        repeat (2) @(negedge clk);
        check(perr, 1'b1);
        pm = 1'b0;
        $display("test parity error finished");
        set_fmt(5'h1b);
        send(8'h00);
        repeat (150) @(negedge clk);
        mrst = 1'b1;
        @(negedge clk);
        mrst = 1'b0;
        check({so, done, empty, perr, len_q, pd_q, ev_q, two_q}, 12'h1c0);
        $display("test master reset finished");
        final_report();
    end
    initial begin
        repeat (80000) @(posedge clk);
        fails++;
        final_report();
    end
endmodule : utfc_tx_tb
`default_nettype wire
